// >>> core/and_branch_pkg.sv
// shared constants and types for the and/branch execute slice
// assumes one 125 MHz core clock split into four phases by a divider
package and_branch_pkg;

  // instruction cycle phases, one clock each
  localparam logic [1:0]  PH_Q1          = 2'h0;
  localparam logic [1:0]  PH_Q2          = 2'h1;
  localparam logic [1:0]  PH_Q3          = 2'h2;
  localparam logic [1:0]  PH_Q4          = 2'h3;
  localparam logic [1:0]  PH_STEP        = 2'h1;

  // opcode fields
  localparam logic [7:0]  OPC_AND_LIT    = 8'h0B;
  localparam logic [5:0]  OPC_AND_REG    = 6'h05;
  localparam logic [7:0]  OPC_BR_CARRY   = 8'hE2;
  localparam int          POS_DEST       = 9;
  localparam int          POS_BANK_ACC   = 8;

  // data addressing
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0]  ILO_MAX        = 8'h5F;
  localparam int          DADDR_W        = 12;
  localparam int          PC_W           = 21;
  localparam logic [20:0] PC_STEP        = 21'h000002;

  // reset values
  // all ones, so that and-results stay observable: and can only clear bits of w
  localparam logic [7:0]  W_RESET        = 8'hFF;
  localparam logic [20:0] PC_RESET       = 21'h000000;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_AND_LIT,
    OP_AND_REG,
    OP_BRANCH
  } op_type;

endpackage

// >>> core/phase_divider.sv
// four-phase divider: one phase per core clock, free running from reset
// assumes synchronous active-low reset on the same clock
`timescale 1ns/1ps
module phase_divider (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  output logic [1:0]      o_phase_r
);

  typedef struct packed {
    logic [1:0] phase;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  // wraps Q4 back to Q1 by natural overflow
  always_comb begin
    s_nxt       = s_r;
    s_nxt.phase = s_r.phase + and_branch_pkg::PH_STEP;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      s_r.phase <= and_branch_pkg::PH_Q1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_phase_r = s_r.phase;

endmodule

// >>> core/data_mem.sv
// general purpose register file, 4096 bytes, one write and one read port
// read data is registered: address in one cycle, data the next
`timescale 1ns/1ps
module data_mem (
  input  wire logic        i_core_clk,
  input  wire logic        i_we,
  input  wire logic [11:0] i_waddr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [11:0] i_raddr,
  output logic [7:0]       o_rdata_r
);

  logic [7:0] mem_r [0:4095];
  logic [7:0] rdata_r;

  // contents are not cleared by reset, like real file registers
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
    rdata_r <= mem_r[i_raddr];
  end

  assign o_rdata_r = rdata_r;

endmodule

// >>> core/and_branch_core.sv
// execute slice for literal-and, register-and and branch-on-carry
// assumes one instruction offered at a time, held while o_instr_taken_r is low
// carry, bank select and index base come from logic on the same clock
//
// Contract
// RQ1: register-and result is w and the selected file register
// RQ2: register-and decodes from top bits 000101, then d, a, 8-bit f
// RQ3: d zero writes result to w, file register untouched
// RQ4: d one writes result back to the addressed file register
// RQ5: a zero resolves f within the access bank
// RQ6: a one forms the address from bank select and f
// RQ7: extended set with a zero and f at most 5Fh uses indexed offset
// RQ8: register-and is one word and one four-phase cycle
// RQ9: branch decodes from 11100010 plus signed offset, taken only on carry
// RQ10: taken target is branch address plus 2 plus twice the offset
// RQ11: branch takes one cycle not taken, two cycles taken
// RQ12: literal-and writes w and k to w, updates negative and zero
// RQ13: taken branch writes pc in cycle one, then a full no-op cycle
`timescale 1ns/1ps
module and_branch_core (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr,
  input  wire logic [20:0] i_instr_addr,
  input  wire logic        i_carry,
  input  wire logic [3:0]  i_bank_select_reg,
  input  wire logic        i_ext_set_en,
  input  wire logic [11:0] i_index_base,
  input  wire logic        i_load_we,
  input  wire logic [11:0] i_load_addr,
  input  wire logic [7:0]  i_load_data,
  output logic [1:0]       o_phase_r,
  output logic             o_instr_taken_r,
  output logic             o_done_r,
  output logic             o_unsupported_r,
  output logic [7:0]       o_w_r,
  output logic [20:0]      o_pc_r,
  output logic             o_negative_r,
  output logic             o_zero_r,
  output logic             o_mem_we_r,
  output logic [11:0]      o_mem_waddr_r,
  output logic [7:0]       o_mem_wdata_r
);

  typedef struct packed {
    logic [15:0]                 instr;
    logic [20:0]                 iaddr;
    and_branch_pkg::op_type      op;
    logic                        busy;
    logic                        nop;
    logic                        taken;
    logic [11:0]                 daddr;
    logic [7:0]                  res;
    logic [7:0]                  w;
    logic [20:0]                 pc;
    logic                        neg;
    logic                        zero;
    logic                        mwe;
    logic [11:0]                 maddr;
    logic [7:0]                  mdata;
    logic                        ack;
    logic                        done;
    logic                        unsup;
  } core_state_type;

  core_state_type s_r;
  core_state_type s_nxt;
  logic [1:0]     phase;
  logic [7:0]     mem_rdata;
  logic           mem_we;
  logic [11:0]    mem_waddr;
  logic [7:0]     mem_wdata;
  logic [20:0]    br_target;
  logic [20:0]    seq_pc;

  phase_divider u_phase (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .o_phase_r  (phase)
  );

  // core writes win over the preload port so a program cannot be corrupted mid-run
  assign mem_we    = s_r.mwe | i_load_we;
  assign mem_waddr = s_r.mwe ? s_r.maddr : i_load_addr;
  assign mem_wdata = s_r.mwe ? s_r.mdata : i_load_data;

  data_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_we       (mem_we),
    .i_waddr    (mem_waddr),
    .i_wdata    (mem_wdata),
    .i_raddr    (s_r.daddr),
    .o_rdata_r  (mem_rdata)
  );

  // branch arithmetic: pc already advanced by one word, offset counts words
  assign seq_pc    = s_r.iaddr + and_branch_pkg::PC_STEP;
  assign br_target = seq_pc + {{12{s_r.instr[7]}}, s_r.instr[7:0], 1'b0}; // RQ10

  // opcode decode of the three handled instructions
  function automatic and_branch_pkg::op_type decode(input logic [15:0] ins);
    and_branch_pkg::op_type op;
    op = and_branch_pkg::OP_NONE;
    if (ins[15:8] == and_branch_pkg::OPC_AND_LIT) begin
      op = and_branch_pkg::OP_AND_LIT;
    end else if (ins[15:10] == and_branch_pkg::OPC_AND_REG) begin
      op = and_branch_pkg::OP_AND_REG; // RQ2
    end else if (ins[15:8] == and_branch_pkg::OPC_BR_CARRY) begin
      op = and_branch_pkg::OP_BRANCH; // RQ9
    end
    return op;
  endfunction

  // data address of a file register operand
  function automatic logic [11:0] data_addr(input logic [15:0] ins, input logic [3:0] bank,
                                            input logic ext, input logic [11:0] base);
    logic [7:0]  f;
    logic [11:0] a;
    f = ins[7:0];
    if (ins[and_branch_pkg::POS_BANK_ACC]) begin
      a = {bank, f}; // RQ6
    end else if (ext && (f <= and_branch_pkg::ILO_MAX)) begin
      a = base + {4'h0, f}; // RQ7
    end else if (f < and_branch_pkg::ACCESS_SPLIT) begin
      a = {and_branch_pkg::ACCESS_LO_BANK, f}; // RQ5
    end else begin
      a = {and_branch_pkg::ACCESS_HI_BANK, f}; // RQ5
    end
    return a;
  endfunction

  // one phase per clock: q1 decode, q2 read, q3 process, q4 write
  always_comb begin
    s_nxt       = s_r;
    s_nxt.mwe   = 1'b0;
    s_nxt.ack   = 1'b0;
    s_nxt.done  = 1'b0;
    s_nxt.unsup = 1'b0;
    case (phase)
      and_branch_pkg::PH_Q1: begin
        // no fetch during the dead cycle after a taken branch
        if (!s_r.nop && i_instr_valid) begin
          s_nxt.instr = i_instr;
          s_nxt.iaddr = i_instr_addr;
          s_nxt.op    = decode(i_instr);
          s_nxt.busy  = 1'b1;
          s_nxt.ack   = 1'b1;
          s_nxt.taken = 1'b0;
          s_nxt.daddr = data_addr(i_instr, i_bank_select_reg, i_ext_set_en, i_index_base);
        end
      end
      and_branch_pkg::PH_Q2: begin
        // file register read is in flight, data lands for q3
      end
      and_branch_pkg::PH_Q3: begin
        if (s_r.busy) begin
          case (s_r.op)
            and_branch_pkg::OP_AND_LIT: s_nxt.res = s_r.w & s_r.instr[7:0]; // RQ12
            and_branch_pkg::OP_AND_REG: s_nxt.res = s_r.w & mem_rdata; // RQ1
            and_branch_pkg::OP_BRANCH:  s_nxt.taken = i_carry; // RQ9
            default:                    s_nxt.res = s_r.res;
          endcase
        end
      end
      and_branch_pkg::PH_Q4: begin
        if (s_r.nop) begin
          s_nxt.nop = 1'b0; // RQ13
        end else if (s_r.busy) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1; // RQ8
          s_nxt.pc   = seq_pc;
          case (s_r.op)
            and_branch_pkg::OP_AND_LIT: begin
              s_nxt.w    = s_r.res; // RQ12
              s_nxt.neg  = s_r.res[7];
              s_nxt.zero = (s_r.res == 8'h00);
            end
            and_branch_pkg::OP_AND_REG: begin
              s_nxt.neg  = s_r.res[7];
              s_nxt.zero = (s_r.res == 8'h00);
              if (s_r.instr[and_branch_pkg::POS_DEST]) begin
                s_nxt.mwe   = 1'b1; // RQ4
                s_nxt.maddr = s_r.daddr;
                s_nxt.mdata = s_r.res;
              end else begin
                s_nxt.w = s_r.res; // RQ3
              end
            end
            and_branch_pkg::OP_BRANCH: begin
              if (s_r.taken) begin
                s_nxt.pc  = br_target; // RQ10
                s_nxt.nop = 1'b1; // RQ11
              end
            end
            default: s_nxt.unsup = 1'b1;
          endcase
        end
      end
      default: s_nxt = s_r;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      s_r       <= '0;
      s_r.op    <= and_branch_pkg::OP_NONE;
      s_r.w     <= and_branch_pkg::W_RESET;
      s_r.pc    <= and_branch_pkg::PC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_phase_r       = phase;
  assign o_instr_taken_r = s_r.ack;
  assign o_done_r        = s_r.done;
  assign o_unsupported_r = s_r.unsup;
  assign o_w_r           = s_r.w;
  assign o_pc_r          = s_r.pc;
  assign o_negative_r    = s_r.neg;
  assign o_zero_r        = s_r.zero;
  assign o_mem_we_r      = s_r.mwe;
  assign o_mem_waddr_r   = s_r.maddr;
  assign o_mem_wdata_r   = s_r.mdata;

  // checks on the execute sequence
  logic q4_live;
  assign q4_live = (phase == and_branch_pkg::PH_Q4) && s_r.busy && !s_r.nop;

  property p_decode_reg;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (phase == and_branch_pkg::PH_Q1 && !s_r.nop && i_instr_valid && i_instr[15:10] == and_branch_pkg::OPC_AND_REG)
      |=> (s_r.op == and_branch_pkg::OP_AND_REG);
  endproperty
  a_decode_reg: assert property (p_decode_reg) else $error("register-and not decoded"); // RQ2

  property p_one_cycle;
    @(posedge i_core_clk) disable iff (!i_resetn)
    s_r.ack |-> !s_r.done ##3 s_r.done;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction not done in one cycle"); // RQ8

  property p_lit_w;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (q4_live && s_r.op == and_branch_pkg::OP_AND_LIT)
      |=> (s_r.w == ($past(s_r.res))) && (s_r.zero == (s_r.w == 8'h00)) && (s_r.neg == s_r.w[7]);
  endproperty
  a_lit_w: assert property (p_lit_w) else $error("literal-and result wrong"); // RQ12

  property p_reg_result;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (phase == and_branch_pkg::PH_Q3 && s_r.busy && s_r.op == and_branch_pkg::OP_AND_REG)
      |=> (s_r.res == ($past(s_r.w) & $past(mem_rdata)));
  endproperty
  a_reg_result: assert property (p_reg_result) else $error("register-and result wrong"); // RQ1

  property p_dest_w;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (q4_live && s_r.op == and_branch_pkg::OP_AND_REG && !s_r.instr[9])
      |=> !o_mem_we_r && (o_w_r == $past(s_r.res));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("d=0 did not target w"); // RQ3

  property p_dest_f;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (q4_live && s_r.op == and_branch_pkg::OP_AND_REG && s_r.instr[9])
      |=> o_mem_we_r && (o_mem_waddr_r == $past(s_r.daddr)) && (o_w_r == $past(s_r.w));
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("d=1 did not write file register"); // RQ4

  property p_banked;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (phase == and_branch_pkg::PH_Q1 && !s_r.nop && i_instr_valid && i_instr[8])
      |=> (s_r.daddr == {$past(i_bank_select_reg), $past(i_instr[7:0])});
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong"); // RQ6

  property p_access;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (phase == and_branch_pkg::PH_Q1 && !s_r.nop && i_instr_valid && !i_instr[8] && !i_ext_set_en)
      |=> (s_r.daddr[11:8] == (s_r.instr[7] ? 4'hF : 4'h0)) && (s_r.daddr[7:0] == s_r.instr[7:0]);
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong"); // RQ5

  property p_indexed;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (phase == and_branch_pkg::PH_Q1 && !s_r.nop && i_instr_valid && !i_instr[8] && i_ext_set_en
      && i_instr[7:0] <= and_branch_pkg::ILO_MAX)
      |=> (s_r.daddr == ($past(i_index_base) + {4'h0, s_r.instr[7:0]}));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed offset address wrong"); // RQ7

  property p_taken;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (q4_live && s_r.op == and_branch_pkg::OP_BRANCH && s_r.taken)
      |=> (o_pc_r == $past(br_target)) ##0 s_r.nop [*4] ##1 !s_r.nop;
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch pc or dead cycle wrong"); // RQ13

  property p_not_taken;
    @(posedge i_core_clk) disable iff (!i_resetn)
    (q4_live && s_r.op == and_branch_pkg::OP_BRANCH && !s_r.taken)
      |=> (o_pc_r == $past(s_r.iaddr) + 21'h000002) && !s_r.nop;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken branch pc wrong"); // RQ11

endmodule

// >>> tb/tb.sv
// testbench for the and/branch execute slice: literal-and, register-and, branch-on-carry
// assumes the design sources under core/ are compiled first; drives every input itself
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module tb;
  typedef struct packed { logic [15:0] ins; logic [20:0] addr; } step_type;
  logic        i_core_clk        = 1'b0;
  logic        i_resetn          = 1'b0;
  logic        i_instr_valid     = 1'b0;
  logic [15:0] i_instr           = 16'h0000;
  logic [20:0] i_instr_addr      = 21'h000000;
  logic        i_carry           = 1'b0;
  logic [3:0]  i_bank_select_reg = 4'h0;
  logic        i_ext_set_en      = 1'b0;
  logic [11:0] i_index_base      = 12'h123;
  logic        i_load_we         = 1'b0;
  logic [11:0] i_load_addr       = 12'h000;
  logic [7:0]  i_load_data       = 8'h00;
  logic [1:0]  o_phase_r;
  logic        o_instr_taken_r, o_done_r, o_unsupported_r, o_negative_r, o_zero_r, o_mem_we_r;
  logic [7:0]  o_w_r, o_mem_wdata_r, wr_data;
  logic [20:0] o_pc_r;
  logic [11:0] o_mem_waddr_r, wr_addr;
  int          err_total = 0, check_count = 0, cyc = 0, done_cnt = 0, wr_cnt = 0, unsup_cnt = 0;
  int          taken_q[$];
  logic [20:0] pc_done[$];
  step_type    prog_q[$];
  // addressing table: f, a, bank select, extended set, expected file address
  logic [7:0]  at_f   [6] = '{8'h30, 8'h90, 8'h45, 8'h5F, 8'h60, 8'h10};
  logic        at_a   [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [3:0]  at_bsr [6] = '{4'h9, 4'h9, 4'h3, 4'h9, 4'h9, 4'h7};
  logic        at_ext [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [11:0] at_exp [6] = '{12'h030, 12'hF90, 12'h345, 12'h182, 12'h060, 12'h710};
  // branch table: carry, offset, address, target, gap between accepted words
  logic        bt_c   [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [7:0]  bt_n   [5] = '{8'h05, 8'hFB, 8'h05, 8'h80, 8'h7F};
  logic [20:0] bt_adr [5] = '{21'h000100, 21'h000100, 21'h000100, 21'h000200, 21'h000200};
  logic [20:0] bt_exp [5] = '{21'h00010C, 21'h0000F8, 21'h000102, 21'h000102, 21'h000300};
  int          bt_gap [5] = '{8, 8, 4, 8, 8};
  logic [15:0] bad_op [2] = '{16'hE305, 16'h1812};

  always #4 i_core_clk = ~i_core_clk;

  and_branch_core dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_instr_addr(i_instr_addr), .i_carry(i_carry), .i_bank_select_reg(i_bank_select_reg),
    .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base), .i_load_we(i_load_we),
    .i_load_addr(i_load_addr), .i_load_data(i_load_data), .o_phase_r(o_phase_r),
    .o_instr_taken_r(o_instr_taken_r), .o_done_r(o_done_r), .o_unsupported_r(o_unsupported_r),
    .o_w_r(o_w_r), .o_pc_r(o_pc_r), .o_negative_r(o_negative_r), .o_zero_r(o_zero_r),
    .o_mem_we_r(o_mem_we_r), .o_mem_waddr_r(o_mem_waddr_r), .o_mem_wdata_r(o_mem_wdata_r));

  // one-cycle pulses are logged here so tests can look at them after the fact
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_instr_taken_r === 1'b1) taken_q.push_back(cyc);
    if (o_done_r === 1'b1) begin
      done_cnt <= done_cnt + 1;
      pc_done.push_back(o_pc_r);
    end
    if (o_unsupported_r === 1'b1) unsup_cnt <= unsup_cnt + 1;
    if (o_mem_we_r === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_addr <= o_mem_waddr_r;
      wr_data <= o_mem_wdata_r;
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // file register preload while the slice is idle; a spare edge keeps clear of its read
  task automatic preload(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_load_we   <= 1'b1;
    i_load_addr <= a;
    i_load_data <= d;
    @(posedge i_core_clk);
    i_load_we   <= 1'b0;
  endtask

  // offers the queued words in order, each held until its accept pulse is seen
  task automatic run();
    int n;
    int d0;
    bit seen;
    n  = prog_q.size();
    d0 = done_cnt;
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      i_instr       <= prog_q[i].ins;
      i_instr_addr  <= prog_q[i].addr;
      i_instr_valid <= 1'b1;
      seen = 1'b0;
      for (int k = 0; k < 32 && !seen; k++) begin
        @(posedge i_core_clk);
        #1;
        seen = (o_instr_taken_r === 1'b1);
      end
      `CHK("taken", 1'b1, seen)
      `CHK("taken_phase", and_branch_pkg::PH_Q2, o_phase_r)
    end
    @(posedge i_core_clk);
    i_instr_valid <= 1'b0;
    for (int k = 0; k < 64 && done_cnt < d0 + n; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    `CHK("done_count", d0 + n, done_cnt)
    prog_q.delete();
  endtask

  initial begin
    int w0;
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    #1;
    `CHK("w_reset", and_branch_pkg::W_RESET, o_w_r)
    `CHK("pc_reset", and_branch_pkg::PC_RESET, o_pc_r)
    // literal-and pair back to back from an all-ones w: negative set, one word each
    prog_q.push_back('{{and_branch_pkg::OPC_AND_LIT, 8'hA3}, 21'h000040});
    prog_q.push_back('{{and_branch_pkg::OPC_AND_LIT, 8'hE1}, 21'h000042});
    run();
    `CHK("lit_w", 8'hA1, o_w_r)
    `CHK("lit_zero", 1'b0, o_zero_r)
    `CHK("lit_neg", 1'b1, o_negative_r)
    `CHK("lit_pc", 21'h000044, o_pc_r)
    `CHK("lit_gap", 4, taken_q[$] - taken_q[$ - 1])
    // register-and to w: the file register must not be written
    preload(12'h030, 8'h5F);
    w0 = wr_cnt;
    prog_q.push_back('{{and_branch_pkg::OPC_AND_REG, 1'b0, 1'b0, 8'h30}, 21'h000050});
    run();
    `CHK("regw_nowrite", w0, wr_cnt)
    `CHK("regw_w", 8'h01, o_w_r)
    `CHK("regw_neg", 1'b0, o_negative_r)
    `CHK("regw_pc", 21'h000052, o_pc_r)
    // register-and back to the file: access bank, bank select and indexed offset
    for (int i = 0; i < 6; i++) begin
      @(posedge i_core_clk);
      i_bank_select_reg <= at_bsr[i];
      i_ext_set_en      <= at_ext[i];
      preload(at_exp[i], 8'h3D);
      w0 = wr_cnt;
      prog_q.push_back('{{and_branch_pkg::OPC_AND_REG, 1'b1, at_a[i], at_f[i]}, 21'h000060});
      run();
      `CHK("regf_count", w0 + 1, wr_cnt)
      `CHK("regf_addr", at_exp[i], wr_addr)
      `CHK("regf_data", 8'h01, wr_data)
    end
    // branch-on-carry followed at once by a literal-and at the target
    for (int i = 0; i < 5; i++) begin
      @(posedge i_core_clk);
      i_carry <= bt_c[i];
      prog_q.push_back('{{and_branch_pkg::OPC_BR_CARRY, bt_n[i]}, bt_adr[i]});
      prog_q.push_back('{{and_branch_pkg::OPC_AND_LIT, 8'h00}, bt_exp[i]});
      run();
      `CHK("br_pc", bt_exp[i], pc_done[$ - 1])
      `CHK("br_gap", bt_gap[i], taken_q[$] - taken_q[$ - 1])
    end
    `CHK("lit_w_end", 8'h00, o_w_r)
    `CHK("lit_zero_end", 1'b1, o_zero_r)
    // neighbouring encodings are not decoded as any of the three
    for (int i = 0; i < 2; i++) begin
      w0 = unsup_cnt;
      prog_q.push_back('{bad_op[i], 21'h000400});
      run();
      `CHK("unsup", w0 + 1, unsup_cnt)
      `CHK("unsup_pc", 21'h000402, o_pc_r)
    end
    give_verdict();
  end

  // the whole sequence needs a few hundred cycles; this is far beyond it
  initial begin
    #200000;
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule
